// ### ccr_pkg.sv
package ccr_pkg;

  // Data-space addresses of the mapped core registers.
  localparam logic [7:0] CCR_ADDR_PTR_ONE = 8'h80;
  localparam logic [7:0] CCR_ADDR_PTR_TWO = 8'h81;
  localparam logic [7:0] CCR_ADDR_SD_ONE  = 8'h82;
  localparam logic [7:0] CCR_ADDR_SD_TWO  = 8'h83;
  localparam logic [7:0] CCR_ADDR_ACC     = 8'hff;

  localparam int         CCR_PC_W         = 12;
  localparam int         CCR_DATA_W       = 8;
  localparam int         CCR_STACK_DEPTH  = 6;

  localparam logic [7:0]  CCR_REG_RST      = 8'h00;
  localparam logic [11:0] CCR_PC_ONE       = 12'h001;
  localparam logic [11:0] CCR_RESET_VECTOR = 12'hffe;
  localparam logic [11:0] CCR_PC_RST       = 12'h000;

  // Clock division ratios.
  localparam logic [3:0] CCR_PERIPH_DIV    = 4'hc;
  localparam logic [3:0] CCR_CORE_DIV      = 4'hd;
  localparam logic [1:0] CCR_OSC_DIV1      = 2'h0;
  localparam logic [1:0] CCR_OSC_DIV2      = 2'h1;
  localparam logic [1:0] CCR_OSC_DIV4      = 2'h3;

  typedef enum logic [1:0] {
    CCR_CTX_MAIN = 2'b00,
    CCR_CTX_INT  = 2'b01,
    CCR_CTX_NMI  = 2'b10
  } ccr_ctx_e;

  typedef enum logic [2:0] {
    CCR_PC_HOLD   = 3'b000,
    CCR_PC_INCR   = 3'b001,
    CCR_PC_REL    = 3'b010,
    CCR_PC_JUMP   = 3'b011,
    CCR_PC_CALL   = 3'b100,
    CCR_PC_INTENT = 3'b101,
    CCR_PC_RET    = 3'b110,
    CCR_PC_INTERRUPT_RETURN_INSTR   = 3'b111
  } ccr_pc_op_e;

endpackage : ccr_pkg

// ### ccr_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

// Modulo counter that emits a one-cycle enable every ratio ticks of en_i.
module ccr_clk_div
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Control
  input  wire logic       en_i,
  input  wire logic [3:0] ratio_i,
  // Output
  output logic            tick_o
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } ccr_div_s;

  ccr_div_s st_r;
  ccr_div_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (en_i) begin
      if (st_r.cnt >= ratio_i - 4'h1) begin
        st_nxt.cnt  = 4'h0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule : ccr_clk_div

`default_nettype wire

// ### ccr_core_regs.sv
// Operation
// - Eight-bit accumulator, read and written in data space at FFh.
// - Two eight-bit pointer registers mapped at 80h and 81h.
// - Two short-direct registers mapped at 82h and 83h.
// - Program counter is 12 bits, addressing 4096 program bytes.
// - Program counter advances by one after each fetched byte.
// - Relative branch adds the signed offset to the program counter.
// - Jump, call, interrupt, reset and returns load the program counter.
// - Three carry/zero pairs: main, maskable interrupt, non-maskable interrupt.
// - Interrupt entry switches flag pair; return restores the previous pair.
// - Context switches never alter any pair; only the active pair changes.
// - Active carry takes carry/borrow, tested bit, and feeds rotate left.
// - Active zero is set when the last result is zero.
// - After reset the non-maskable context and its flags are active.
// - Six-level 12-bit stack pushes program counter, drops sixth level.
// - Either return pops level one into the program counter.
// - More than six nestings saturate the stack, losing oldest address.
// - Return on empty stack keeps stack at top and continues.
// - Internal clock divided by 12 for peripherals, 13 for core.
// - Instructions take two, four or five machine cycles.
// - Oscillator divider gives 1, 2 or 4; codes 10 and 11 give 4.
`timescale 1ns/1ps
`default_nettype none

module ccr_core_regs
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Clock divider select
  input  wire logic        divider_select_hi_i,
  input  wire logic        divider_select_lo_i,
  // Data-space access
  input  wire logic        ds_wr_i,
  input  wire logic [7:0]  ds_addr_i,
  input  wire logic [7:0]  ds_wdata_i,
  output logic      [7:0]  ds_rdata_o,
  output logic             ds_hit_o,
  // Execution control, sampled on machine-cycle ticks
  input  wire logic [2:0]  pc_op_i,
  input  wire logic [11:0] pc_target_i,
  input  wire logic [7:0]  rel_offset_i,
  input  wire logic        int_is_nmi_i,
  input  wire logic [1:0]  instr_cycles_i,
  // ALU result and flag update
  input  wire logic        acc_wr_i,
  input  wire logic [7:0]  acc_wdata_i,
  input  wire logic        carry_wr_i,
  input  wire logic        carry_i,
  input  wire logic        zero_wr_i,
  input  wire logic [7:0]  result_i,
  // Core state
  output logic      [11:0] program_counter_o,
  output logic             carry_o,
  output logic             zero_o,
  output logic      [1:0]  ctx_o,
  output logic      [2:0]  stack_level_o,
  output logic             instr_done_o,
  // Clock enables
  output logic             core_tick_o,
  output logic             periph_tick_o
);

  typedef struct packed {
    logic [7:0]                      acc;
    logic [7:0]                      ptr_one;
    logic [7:0]                      ptr_two;
    logic [7:0]                      sd_one;
    logic [7:0]                      sd_two;
    logic [11:0]                     pc;
    logic [2:0]                      carry;
    logic [2:0]                      zero;
    ccr_ctx_e                        ctx;
    ccr_ctx_e                        prev_ctx;
    logic [CCR_STACK_DEPTH-1:0][11:0] stk;
    logic [2:0]                      lvl;
    logic [1:0]                      osc_cnt;
    logic [2:0]                      mc_cnt;
    logic                            done;
    logic [7:0]                      rdata;
    logic                            hit;
    logic                            sel_hi_s1;
    logic                            sel_hi_s2;
    logic                            sel_lo_s1;
    logic                            sel_lo_s2;
    logic                            act_carry;
    logic                            act_zero;
  } ccr_core_s;

  ccr_core_s st_r;
  ccr_core_s st_nxt;

  logic       int_tick;
  logic       core_tick;
  logic       periph_tick;
  logic [1:0] div_sel;
  logic [2:0] need_cycles;

  assign div_sel = {st_r.sel_hi_s2, st_r.sel_lo_s2};

  // Code 11 is folded onto divide by four, the same as code 10.
  always_comb begin
    case (div_sel)
      CCR_OSC_DIV1: int_tick = 1'b1;
      CCR_OSC_DIV2: int_tick = st_r.osc_cnt[0];
      default:      int_tick = (st_r.osc_cnt == CCR_OSC_DIV4);
    endcase
  end

  ccr_clk_div u_core_div (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .en_i      (int_tick),
    .ratio_i   (CCR_CORE_DIV),
    .tick_o    (core_tick)
  );

  ccr_clk_div u_periph_div (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .en_i      (int_tick),
    .ratio_i   (CCR_PERIPH_DIV),
    .tick_o    (periph_tick)
  );

  // Encoded length 0,1,2 means two, four or five machine cycles.
  always_comb begin
    case (instr_cycles_i)
      2'h0:    need_cycles = 3'h2;
      2'h1:    need_cycles = 3'h4;
      default: need_cycles = 3'h5;
    endcase
  end

  always_comb begin
    st_nxt           = st_r;
    st_nxt.sel_hi_s1 = divider_select_hi_i;
    st_nxt.sel_hi_s2 = st_r.sel_hi_s1;
    st_nxt.sel_lo_s1 = divider_select_lo_i;
    st_nxt.sel_lo_s2 = st_r.sel_lo_s1;
    st_nxt.osc_cnt   = st_r.osc_cnt + 2'h1;
    st_nxt.done      = 1'b0;

    // Data-space read port, registered for a clean output.
    st_nxt.hit = 1'b1;
    case (ds_addr_i)
      CCR_ADDR_PTR_ONE: st_nxt.rdata = st_r.ptr_one;
      CCR_ADDR_PTR_TWO: st_nxt.rdata = st_r.ptr_two;
      CCR_ADDR_SD_ONE:  st_nxt.rdata = st_r.sd_one;
      CCR_ADDR_SD_TWO:  st_nxt.rdata = st_r.sd_two;
      CCR_ADDR_ACC:     st_nxt.rdata = st_r.acc;
      default: begin
        st_nxt.rdata = CCR_REG_RST;
        st_nxt.hit   = 1'b0;
      end
    endcase

    // Data-space writes act immediately; they are not tied to the core tick.
    if (ds_wr_i) begin
      case (ds_addr_i)
        CCR_ADDR_PTR_ONE: st_nxt.ptr_one = ds_wdata_i;
        CCR_ADDR_PTR_TWO: st_nxt.ptr_two = ds_wdata_i;
        CCR_ADDR_SD_ONE:  st_nxt.sd_one  = ds_wdata_i;
        CCR_ADDR_SD_TWO:  st_nxt.sd_two  = ds_wdata_i;
        CCR_ADDR_ACC:     st_nxt.acc     = ds_wdata_i;
        default: ;
      endcase
    end

    if (core_tick) begin
      // ALU accumulator write wins over a data-space write in the same tick.
      if (acc_wr_i) begin
        st_nxt.acc = acc_wdata_i;
      end
      if (carry_wr_i) begin
        st_nxt.carry[st_r.ctx] = carry_i;
      end
      if (zero_wr_i) begin
        st_nxt.zero[st_r.ctx] = (result_i == CCR_REG_RST);
      end

      if (st_r.mc_cnt + 3'h1 >= need_cycles) begin
        st_nxt.mc_cnt = 3'h0;
        st_nxt.done   = 1'b1;
      end else begin
        st_nxt.mc_cnt = st_r.mc_cnt + 3'h1;
      end

      case (pc_op_i)
        CCR_PC_INCR: st_nxt.pc = st_r.pc + CCR_PC_ONE;
        CCR_PC_REL: begin
          st_nxt.pc = st_r.pc + {{4{rel_offset_i[7]}}, rel_offset_i};
        end
        CCR_PC_JUMP: st_nxt.pc = pc_target_i;
        CCR_PC_CALL, CCR_PC_INTENT: begin
          st_nxt.pc = pc_target_i;
          for (int i = CCR_STACK_DEPTH - 1; i > 0; i--) begin
            st_nxt.stk[i] = st_r.stk[i-1];
          end
          st_nxt.stk[0] = st_r.pc;
          if (st_r.lvl != 3'(CCR_STACK_DEPTH)) begin
            st_nxt.lvl = st_r.lvl + 3'h1;
          end
          if (pc_op_i == CCR_PC_INTENT) begin
            // Flag pairs are left untouched; only the selector moves.
            st_nxt.prev_ctx = st_r.ctx;
            st_nxt.ctx = int_is_nmi_i ? CCR_CTX_NMI : CCR_CTX_INT;
          end
        end
        CCR_PC_RET, CCR_PC_INTERRUPT_RETURN_INSTR: begin
          // An empty stack pops nothing and execution falls through.
          if (st_r.lvl != 3'h0) begin
            st_nxt.pc = st_r.stk[0];
            for (int i = 0; i < CCR_STACK_DEPTH - 1; i++) begin
              st_nxt.stk[i] = st_r.stk[i+1];
            end
            st_nxt.lvl = st_r.lvl - 3'h1;
          end else begin
            st_nxt.pc = st_r.pc + CCR_PC_ONE;
          end
          if (pc_op_i == CCR_PC_INTERRUPT_RETURN_INSTR) begin
            // Only one level of context history is kept; nested returns go to main.
            st_nxt.ctx      = st_r.prev_ctx;
            st_nxt.prev_ctx = CCR_CTX_MAIN;
          end
        end
        default: ;
      endcase
    end

    // The active pair is registered so that the flag outputs leave a flip-flop.
    st_nxt.act_carry = st_nxt.carry[st_nxt.ctx];
    st_nxt.act_zero  = st_nxt.zero[st_nxt.ctx];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r          <= '0;
      st_r.pc       <= CCR_RESET_VECTOR;
      st_r.ctx      <= CCR_CTX_NMI;
      st_r.prev_ctx <= CCR_CTX_MAIN;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_tick_o   <= 1'b0;
      periph_tick_o <= 1'b0;
    end else begin
      core_tick_o   <= core_tick;
      periph_tick_o <= periph_tick;
    end
  end

  assign ds_rdata_o        = st_r.rdata;
  assign ds_hit_o          = st_r.hit;
  assign program_counter_o = st_r.pc;
  assign carry_o           = st_r.act_carry;
  assign zero_o            = st_r.act_zero;
  assign ctx_o             = st_r.ctx;
  assign stack_level_o     = st_r.lvl;
  assign instr_done_o      = st_r.done;

endmodule : ccr_core_regs

`default_nettype wire

// ### ccr_core_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_core_regs_chk
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  // Watched ports
  input wire logic        divider_select_hi_i,
  input wire logic        divider_select_lo_i,
  input wire logic        ds_wr_i,
  input wire logic [7:0]  ds_addr_i,
  input wire logic [7:0]  ds_wdata_i,
  input wire logic [7:0]  ds_rdata_o,
  input wire logic [2:0]  pc_op_i,
  input wire logic [11:0] pc_target_i,
  input wire logic        int_is_nmi_i,
  input wire logic [11:0] program_counter_o,
  input wire logic [1:0]  ctx_o,
  input wire logic [2:0]  stack_level_o,
  input wire logic        core_tick_o,
  input wire logic        periph_tick_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire map_w = (ds_addr_i[7:2] == 6'h20) || (ds_addr_i == 8'hff);
  chk_reset_state: assert property (
    $rose(rstn_i) |-> program_counter_o == CCR_RESET_VECTOR && ctx_o == CCR_CTX_NMI)
    else $error("bad state after reset");
  chk_map_rw: assert property (
    (ds_wr_i && map_w) ##1 (!ds_wr_i && $stable(ds_addr_i)) |=> ds_rdata_o == $past(ds_wdata_i, 2))
    else $error("mapped register lost its write");
  // Both periods hold only while the divider pins select divide by one.
  chk_core_period: assert property (
    disable iff (!rstn_i || divider_select_hi_i || divider_select_lo_i)
    core_tick_o |=> (!core_tick_o)[*8] ##1 (!core_tick_o)[*4] ##1 core_tick_o)
    else $error("core tick period wrong");
  chk_periph_period: assert property (
    disable iff (!rstn_i || divider_select_hi_i || divider_select_lo_i)
    periph_tick_o |-> ##12 periph_tick_o)
    else $error("peripheral tick period wrong");
  chk_pc_hold: assert property (
    !core_tick_o |-> $stable(program_counter_o))
    else $error("program counter moved off a tick");
  chk_jump_load: assert property (
    core_tick_o && $past(pc_op_i) == CCR_PC_JUMP |-> program_counter_o == $past(pc_target_i))
    else $error("jump target not loaded");
  chk_call_push: assert property (
    core_tick_o && $past(pc_op_i) == CCR_PC_CALL |-> stack_level_o ==
      (($past(stack_level_o) == 3'h6) ? 3'h6 : $past(stack_level_o) + 3'h1))
    else $error("stack depth wrong after call");
  chk_ctx_enter: assert property (
    core_tick_o && $past(pc_op_i) == CCR_PC_INTENT |->
      ctx_o == ($past(int_is_nmi_i) ? CCR_CTX_NMI : CCR_CTX_INT))
    else $error("context wrong after interrupt entry");
  cov_stack_full: cover property (core_tick_o && stack_level_o == 3'h6);
  cov_int_ctx: cover property (ctx_o == CCR_CTX_INT);
  cov_main_ctx: cover property (ctx_o == CCR_CTX_MAIN);
endmodule : ccr_core_regs_chk
bind ccr_core_regs ccr_core_regs_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .divider_select_hi_i(divider_select_hi_i), .divider_select_lo_i(divider_select_lo_i),
  .ds_wr_i(ds_wr_i), .ds_addr_i(ds_addr_i), .ds_wdata_i(ds_wdata_i), .ds_rdata_o(ds_rdata_o),
  .pc_op_i(pc_op_i), .pc_target_i(pc_target_i), .int_is_nmi_i(int_is_nmi_i),
  .program_counter_o(program_counter_o), .ctx_o(ctx_o), .stack_level_o(stack_level_o),
  .core_tick_o(core_tick_o), .periph_tick_o(periph_tick_o));
`default_nettype wire

// ### ccr_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sequencer stand-in: holds one request until the core tick shows it was taken.
module ccr_exec_model
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Request
  input  wire logic        go_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [11:0] arg_i,
  input  wire logic [2:0]  fl_i,
  input  wire logic        core_tick_i,
  // Toward the core
  output logic      [2:0]  pc_op_o,
  output logic      [11:0] pc_target_o,
  output logic      [7:0]  rel_offset_o,
  output logic      [7:0]  result_o,
  output logic             int_is_nmi_o,
  output logic      [2:0]  flag_wr_o,
  output logic             busy_o
);
  // A tick seen in the first cycle of a request was launched before the request
  // stood, so it did not take it; only later ticks may release the request.
  logic armed_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {busy_o, pc_op_o, flag_wr_o} <= 7'h00;
      {pc_target_o, rel_offset_o, result_o, int_is_nmi_o} <= 29'h0;
      armed_r <= 1'b0;
    end else if (go_i && !busy_o) begin
      {busy_o, pc_op_o, flag_wr_o} <= {1'b1, op_i, fl_i};
      {pc_target_o, rel_offset_o, result_o, int_is_nmi_o} <= {arg_i, arg_i[7:0], arg_i[7:0], arg_i[0]};
      armed_r <= 1'b0;
    end else if (busy_o && core_tick_i && armed_r) begin
      armed_r <= 1'b0;
      // Released data lines flip, so a late sample by the core cannot pass by luck.
      {busy_o, pc_op_o, flag_wr_o} <= 7'h00;
      {pc_target_o, rel_offset_o, result_o, int_is_nmi_o} <=
        ~{pc_target_o, rel_offset_o, result_o, int_is_nmi_o};
    end else begin
      armed_r <= busy_o;
    end
  end
endmodule : ccr_exec_model
`default_nettype wire

// ### cpu_core_registers_stack_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module cpu_core_registers_stack_bench
  import ccr_pkg::*;
;
  logic        ref_clk_i = 1'b0, rstn_i = 1'b0, ds_wr = 1'b0, go = 1'b0;
  logic [7:0]  ds_addr = 8'h00, ds_wdata = 8'h00, ds_rdata, rel_offset, result;
  logic [2:0]  op = 3'h0, fl = 3'h0, pc_op, stack_level, flag_wr;
  logic [11:0] arg = 12'h000, pc_target, pc;
  logic [1:0]  ctx, cyc = 2'h0;
  logic        ds_hit, int_is_nmi, carry, zero, busy, core_tick, done, periph_tick;
  logic        sel_hi = 1'b0, sel_lo = 1'b0, acc_wr = 1'b0;
  int          err_total = 0, checks = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  ccr_core_regs DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .divider_select_hi_i(sel_hi), .divider_select_lo_i(sel_lo),
    .ds_wr_i(ds_wr), .ds_addr_i(ds_addr), .ds_wdata_i(ds_wdata), .ds_rdata_o(ds_rdata),
    .ds_hit_o(ds_hit), .pc_op_i(pc_op), .pc_target_i(pc_target), .rel_offset_i(rel_offset),
    .int_is_nmi_i(int_is_nmi), .instr_cycles_i(cyc), .acc_wr_i(acc_wr), .acc_wdata_i(result),
    .carry_wr_i(flag_wr[2]), .carry_i(flag_wr[1]), .zero_wr_i(flag_wr[0]), .result_i(result),
    .program_counter_o(pc), .carry_o(carry), .zero_o(zero), .ctx_o(ctx),
    .stack_level_o(stack_level), .instr_done_o(done), .core_tick_o(core_tick),
    .periph_tick_o(periph_tick));
  ccr_exec_model u_exec (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .go_i(go), .op_i(op),
    .arg_i(arg), .fl_i(fl), .core_tick_i(core_tick), .pc_op_o(pc_op), .pc_target_o(pc_target),
    .rel_offset_o(rel_offset), .result_o(result), .int_is_nmi_o(int_is_nmi),
    .flag_wr_o(flag_wr), .busy_o(busy));
  task wrap_up;
    $display("err_total=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task exec(input logic [2:0] o, input logic [11:0] a, input logic [2:0] f);
    int n;
    @(posedge ref_clk_i);
    {go, op, arg, fl} <= {1'b1, o, a, f};
    @(posedge ref_clk_i);
    go <= 1'b0;
    #1;
    for (n = 0; busy !== 1'b0 && n < 40; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 40) begin
      err_total++;
      wrap_up();
    end
  endtask : exec
  task rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic h);
    @(posedge ref_clk_i);
    {ds_wr, ds_addr, ds_wdata} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    ds_wr <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK(ds_rdata, e)
    `CHK(ds_hit, h)
  endtask : rw
  task t_reset;
    `CHK(pc, CCR_RESET_VECTOR)
    `CHK(ctx, CCR_CTX_NMI)
    `CHK(stack_level, 3'h0)
  endtask : t_reset
  task t_regs;
    rw(CCR_ADDR_ACC, 8'h5a, 8'h5a, 1'b1);
    rw(CCR_ADDR_PTR_ONE, 8'ha1, 8'ha1, 1'b1);
    rw(CCR_ADDR_PTR_TWO, 8'h3c, 8'h3c, 1'b1);
    rw(CCR_ADDR_SD_ONE, 8'hc3, 8'hc3, 1'b1);
    rw(CCR_ADDR_SD_TWO, 8'h96, 8'h96, 1'b1);
    rw(8'h84, 8'h77, 8'h00, 1'b0);
    @(posedge ref_clk_i);
    acc_wr <= 1'b1;
    exec(CCR_PC_HOLD, 12'h0a5, 3'h0);
    acc_wr <= 1'b0;
    ds_addr <= CCR_ADDR_ACC;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK(ds_rdata, 8'ha5)
  endtask : t_regs
  // Counts clock edges until the chosen pulse (0 core, 1 done, 2 peripheral) is seen.
  task gap(input logic [1:0] w, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (n < 300 && ((w == 2'h0) ? core_tick : (w == 2'h1) ? done : periph_tick) !== 1'b1);
    if (n >= 300) begin
      err_total++;
      wrap_up();
    end
  endtask : gap
  task t_cycles(input logic [1:0] c, input int mc);
    int n;
    @(posedge ref_clk_i);
    cyc <= c;
    repeat (2) gap(2'h1, n);
    gap(2'h1, n);
    `CHK(n, 13 * mc)
  endtask : t_cycles
  task t_div(input logic h, input logic l, input int per);
    int n;
    @(posedge ref_clk_i);
    {sel_hi, sel_lo} <= {h, l};
    repeat (3) gap(2'h0, n);
    gap(2'h0, n);
    `CHK(n, 13 * per)
    gap(2'h2, n);
    gap(2'h2, n);
    `CHK(n, 12 * per)
  endtask : t_div
  task t_pc;
    exec(CCR_PC_JUMP, 12'h7f0, 3'h0);
    `CHK(pc, 12'h7f0)
    exec(CCR_PC_REL, 12'h0fe, 3'h0);
    `CHK(pc, 12'h7ee)
    exec(CCR_PC_JUMP, 12'hfff, 3'h0);
    exec(CCR_PC_INCR, 12'h000, 3'h0);
    `CHK(pc, 12'h000)
  endtask : t_pc
  task t_flags;
    exec(CCR_PC_HOLD, 12'h000, 3'h7);
    `CHK({carry, zero}, 2'b11)
    exec(CCR_PC_INTENT, 12'h0f0, 3'h0);
    `CHK({ctx, pc}, {CCR_CTX_INT, 12'h0f0})
    `CHK({carry, zero}, 2'b00)
    exec(CCR_PC_HOLD, 12'h003, 3'h6);
    `CHK({carry, zero}, 2'b10)
    exec(CCR_PC_INTERRUPT_RETURN_INSTR, 12'h000, 3'h0);
    `CHK({ctx, carry, zero, pc}, {CCR_CTX_NMI, 2'b11, 12'h000})
    exec(CCR_PC_INTERRUPT_RETURN_INSTR, 12'h000, 3'h0);
    `CHK({ctx, carry, zero, pc}, {CCR_CTX_MAIN, 2'b00, 12'h001})
    exec(CCR_PC_INTENT, 12'h0f1, 3'h0);
    `CHK({ctx, carry, zero}, {CCR_CTX_NMI, 2'b11})
    exec(CCR_PC_INTERRUPT_RETURN_INSTR, 12'h000, 3'h0);
    `CHK(ctx, CCR_CTX_MAIN)
  endtask : t_flags
  task t_stack;
    int k;
    for (k = 1; k <= 7; k++) begin
      exec(CCR_PC_CALL, 12'(k * 256), 3'h0);
      `CHK(pc, 12'(k * 256))
      `CHK(stack_level, (k < 6) ? 3'(k) : 3'h6)
    end
    for (k = 6; k >= 1; k--) begin
      exec(CCR_PC_RET, 12'h000, 3'h0);
      `CHK({pc, stack_level}, {12'(k * 256), 3'(k - 1)})
    end
    exec(CCR_PC_RET, 12'h000, 3'h0);
    `CHK({pc, stack_level}, {12'h101, 3'h0})
  endtask : t_stack
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_reset();
    t_regs();
    t_pc();
    t_flags();
    t_stack();
    t_cycles(2'h0, 2);
    t_cycles(2'h1, 4);
    t_cycles(2'h2, 5);
    t_cycles(2'h3, 5);
    t_div(1'b0, 1'b0, 1);
    t_div(1'b0, 1'b1, 2);
    t_div(1'b1, 1'b0, 4);
    t_div(1'b1, 1'b1, 4);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    {sel_hi, sel_lo} <= 2'b00;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_reset();
    wrap_up();
  end
endmodule : cpu_core_registers_stack_bench
`default_nettype wire
